// file: design/packet_data_config_regs.sv
// Packet data configuration register bank with its serial register port.
// Assumes sclk_i only toggles while cs_i is high and the host keeps select
// low between transactions; crc_fail_i and burst_rx_i come from clk_i logic.
`timescale 1ns/100ps
module packet_data_config_regs (
    // System clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Serial register port
    input wire logic sclk_i,
    input wire logic cs_i,
    input wire logic serial_io_line_i,
    output logic serial_io_line_o,
    output logic serial_io_line_oe_o,
    // Signal strength front end
    input wire logic [3:0] analog_signal_level_i,
    output logic level_detect_out_o,
    // Packet engine
    input wire logic crc_fail_i,
    input wire logic burst_rx_i,
    output logic fifo_clear_o,
    output pkt_cfg_pkg::cfg_t cfg_o
);
    // ---------------- Link side, clocked by sclk_i ----------------
    logic [4:0] bit_cnt_r;
    logic [14:0] shift_r;
    pkt_cfg_pkg::frame_t frame_r;
    logic wr_tgl_r;
    logic [7:0] rd_shift_r;
    logic [7:0] rd_byte;
    logic frame_last;
    logic frame_is_write;
    logic read_load;
    logic read_running;

    // ---------------- Core side, clocked by clk_i ----------------
    logic [5:0] sync_q;
    logic cs_s;
    logic wr_tgl_s;
    logic [3:0] level_s;
    logic wr_seen_r;
    logic wr_evt;
    logic [7:0] data_func_r;
    logic [7:0] strength_ctl_r;
    logic [3:0] gain_ctl_r;
    logic [3:0] level_r;
    logic [7:0] data_format_r;
    logic [7:0] mirror_r [pkt_cfg_pkg::REG_COUNT];
    logic [7:0] signal_value;
    logic we_func;
    logic we_strength;
    logic we_value;
    logic we_format;
    logic burst;
    logic refresh_now;
    logic clear_now;
    logic [5:0] payload_bytes;
    pkt_cfg_pkg::cfg_t cfg_nxt;

    // Mapped if the address falls inside the implemented window
    function automatic logic reg_mapped(input logic [6:0] a);
        reg_mapped = (a >= pkt_cfg_pkg::DATA_FUNC_ADDR) && (a <= pkt_cfg_pkg::DATA_FORMAT_ADDR);
    endfunction

    function automatic logic [1:0] reg_slot(input logic [6:0] a);
        logic [6:0] diff;
        diff = a - pkt_cfg_pkg::DATA_FUNC_ADDR;
        reg_slot = diff[1:0];
    endfunction

    // Rising edges sample the host's bits; a dropped select restarts the frame
    always_ff @(posedge sclk_i or negedge cs_i) begin
        if (!cs_i) begin
            bit_cnt_r <= '0;
            shift_r <= '0;
        end else if (bit_cnt_r != 5'(pkt_cfg_pkg::FRAME_BITS)) begin
            shift_r <= {shift_r[13:0], serial_io_line_i};
            bit_cnt_r <= bit_cnt_r + 5'h01;
        end
    end

    assign frame_last = (bit_cnt_r == 5'(pkt_cfg_pkg::FRAME_BITS - 1));
    assign frame_is_write = shift_r[14];

    // Completed write frames are held and announced by a toggle
    always_ff @(posedge sclk_i or posedge reset_i) begin
        if (reset_i) begin
            frame_r <= '0;
            wr_tgl_r <= 1'b0;
        end else if (cs_i && frame_last && frame_is_write) begin
            frame_r <= {shift_r[13:7], shift_r[6:0], serial_io_line_i};
            wr_tgl_r <= ~wr_tgl_r;
        end
    end

    // The mirror only changes while select is low, so it is quiet for the
    // whole frame in which the link side reads it
    assign rd_byte = reg_mapped(shift_r[6:0]) ? mirror_r[reg_slot(shift_r[6:0])] :
                     pkt_cfg_pkg::UNMAPPED_READ;
    assign read_load = (bit_cnt_r == 5'(pkt_cfg_pkg::ADDR_BYTE_BITS)) && !shift_r[7];
    assign read_running = (bit_cnt_r > 5'(pkt_cfg_pkg::ADDR_BYTE_BITS)) &&
                          (bit_cnt_r < 5'(pkt_cfg_pkg::FRAME_BITS));

    // Falling edges move the read byte out, MSB first
    always_ff @(negedge sclk_i or negedge cs_i) begin
        if (!cs_i) begin
            rd_shift_r <= '0;
            serial_io_line_o <= 1'b0;
            serial_io_line_oe_o <= 1'b0;
        end else if (read_load) begin
            rd_shift_r <= {rd_byte[6:0], 1'b0};
            serial_io_line_o <= rd_byte[7];
            serial_io_line_oe_o <= 1'b1;
        end else if (read_running && serial_io_line_oe_o) begin
            rd_shift_r <= {rd_shift_r[6:0], 1'b0};
            serial_io_line_o <= rd_shift_r[7];
        end else if (bit_cnt_r == 5'(pkt_cfg_pkg::FRAME_BITS)) begin
            serial_io_line_oe_o <= 1'b0;
        end
    end

    // Select, write toggle and front-end level all enter the core here
    cdc_sync #(
        .WIDTH(6)
    ) u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .d_i({cs_i, wr_tgl_r, analog_signal_level_i}),
        .q_o(sync_q)
    );

    assign cs_s = sync_q[5];
    assign wr_tgl_s = sync_q[4];
    assign level_s = sync_q[3:0];

    // Frame data is stable for many cycles after the toggle settles
    assign wr_evt = wr_tgl_s ^ wr_seen_r;
    assign we_func = wr_evt && (frame_r.addr == pkt_cfg_pkg::DATA_FUNC_ADDR);
    assign we_strength = wr_evt && (frame_r.addr == pkt_cfg_pkg::STRENGTH_CTL_ADDR);
    assign we_value = wr_evt && (frame_r.addr == pkt_cfg_pkg::SIGNAL_VALUE_ADDR);
    assign we_format = wr_evt && (frame_r.addr == pkt_cfg_pkg::DATA_FORMAT_ADDR);

    // Reserved bits are stored as written; the host keeps them at zero
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wr_seen_r <= wr_tgl_s;
            data_func_r <= pkt_cfg_pkg::DATA_FUNC_RESET;
            strength_ctl_r <= pkt_cfg_pkg::STRENGTH_CTL_RESET;
            gain_ctl_r <= pkt_cfg_pkg::SIGNAL_VALUE_RESET[7:4];
            data_format_r <= pkt_cfg_pkg::DATA_FORMAT_RESET;
        end else begin
            wr_seen_r <= wr_tgl_s;
            if (we_func) begin
                data_func_r <= frame_r.data;
            end
            if (we_strength) begin
                strength_ctl_r <= frame_r.data;
            end
            if (we_value) begin
                gain_ctl_r <= frame_r.data[7:4];
            end
            if (we_format) begin
                data_format_r <= frame_r.data;
            end
        end
    end

    assign burst = data_func_r[pkt_cfg_pkg::DF_MODE_BIT];
    // Refresh control only matters in continuous mode; burst keeps refreshing
    assign refresh_now = burst || strength_ctl_r[pkt_cfg_pkg::SC_REFRESH_BIT];

    // Digitized level is hardware owned; host writes to it are dropped
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            level_r <= pkt_cfg_pkg::SIGNAL_VALUE_RESET[3:0];
        end else if (refresh_now) begin
            level_r <= level_s;
        end
    end

    assign signal_value = {gain_ctl_r, level_r};

    // Mirror for the link side, frozen while a frame may be in progress
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mirror_r[0] <= pkt_cfg_pkg::DATA_FUNC_RESET;
            mirror_r[1] <= pkt_cfg_pkg::STRENGTH_CTL_RESET;
            mirror_r[2] <= pkt_cfg_pkg::SIGNAL_VALUE_RESET;
            mirror_r[3] <= pkt_cfg_pkg::DATA_FORMAT_RESET;
        end else if (!cs_s) begin
            mirror_r[0] <= data_func_r;
            mirror_r[1] <= strength_ctl_r;
            mirror_r[2] <= signal_value;
            mirror_r[3] <= data_format_r;
        end
    end

    assign clear_now = crc_fail_i && burst_rx_i && burst &&
                       !data_func_r[pkt_cfg_pkg::DF_KEEP_BIT];
    assign payload_bytes = {1'b0, data_format_r[4:0]} + 6'h01;

    // Mode gating so idle fields read as their inactive level downstream
    assign cfg_nxt.burst_mode = burst;
    assign cfg_nxt.bit_rate_select = data_func_r[pkt_cfg_pkg::DF_RATE_BIT];
    assign cfg_nxt.scramble_enable = burst && data_func_r[pkt_cfg_pkg::DF_SCRAMBLE_BIT];
    assign cfg_nxt.crc_enable = burst && data_func_r[pkt_cfg_pkg::DF_CRC_BIT];
    assign cfg_nxt.crc_keep_on_error = data_func_r[pkt_cfg_pkg::DF_KEEP_BIT];
    assign cfg_nxt.analog_level_refresh = refresh_now;
    assign cfg_nxt.level_threshold = strength_ctl_r[3:0];
    assign cfg_nxt.auto_gain_enable = !burst && gain_ctl_r[1];
    assign cfg_nxt.level_gain_select = !burst && gain_ctl_r[0];
    assign cfg_nxt.sender_addr_insert_n =
        !burst || data_format_r[pkt_cfg_pkg::FMT_INSERT_BIT];
    assign cfg_nxt.sender_addr_output_n =
        !burst || data_format_r[pkt_cfg_pkg::FMT_OUTPUT_BIT];
    assign cfg_nxt.dest_addr_source = burst && data_format_r[pkt_cfg_pkg::FMT_DEST_BIT];
    assign cfg_nxt.payload_bytes = payload_bytes;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cfg_o <= '0;
            level_detect_out_o <= 1'b0;
            fifo_clear_o <= 1'b0;
        end else begin
            cfg_o <= cfg_nxt;
            level_detect_out_o <= (level_s > strength_ctl_r[3:0]);
            fifo_clear_o <= clear_now;
        end
    end

    // ---------------- Checks ----------------
    sequence s_read_request;
        read_load;
    endsequence

    sequence s_read_byte_out;
        serial_io_line_oe_o [*8];
    endsequence

    property p_read_drives_byte;
        @(negedge sclk_i) disable iff (!cs_i || reset_i)
        s_read_request |=> s_read_byte_out;
    endproperty
    a_read_drives_byte: assert property (p_read_drives_byte)
        else $error("read byte not driven for eight falling edges");

    // Checked on falling edges: the rise that completes a frame is its last rise
    property p_write_frame_toggles;
        @(negedge sclk_i) disable iff (!cs_i || reset_i)
        (frame_last && frame_is_write) |=> (wr_tgl_r != $past(wr_tgl_r)) &&
            (frame_r.addr == $past(shift_r[13:7]));
    endproperty
    a_write_frame_toggles: assert property (p_write_frame_toggles)
        else $error("completed write frame did not raise a write event");

    property p_write_lands;
        @(posedge clk_i) disable iff (reset_i)
        we_func |=> (data_func_r == $past(frame_r.data)) ##1 cfg_o.burst_mode == data_func_r[6];
    endproperty
    a_write_lands: assert property (p_write_lands)
        else $error("data function write not applied");

    property p_burst_fields_idle;
        @(posedge clk_i) disable iff (reset_i)
        (!burst && $stable(burst)) |=> !cfg_o.scramble_enable && !cfg_o.crc_enable &&
            cfg_o.sender_addr_insert_n && cfg_o.sender_addr_output_n;
    endproperty
    a_burst_fields_idle: assert property (p_burst_fields_idle)
        else $error("burst-only field active in continuous mode");

    property p_payload_count;
        @(posedge clk_i) disable iff (reset_i)
        // The release edge still loads the cleared output, so start one edge later
        !reset_i |=> (cfg_o.payload_bytes == 6'($past(data_format_r[4:0])) + 6'h01);
    endproperty
    a_payload_count: assert property (p_payload_count)
        else $error("payload byte count is not field plus one");

    property p_level_holds;
        @(posedge clk_i) disable iff (reset_i)
        (!refresh_now && !burst) |=> $stable(level_r);
    endproperty
    a_level_holds: assert property (p_level_holds)
        else $error("signal level changed while refresh is off");

    property p_detect_follows;
        @(posedge clk_i) disable iff (reset_i)
        (level_s > strength_ctl_r[3:0]) |=> level_detect_out_o;
    endproperty
    a_detect_follows: assert property (p_detect_follows)
        else $error("detect output low while level exceeds threshold");

    property p_detect_low;
        @(posedge clk_i) disable iff (reset_i)
        (!reset_i && (level_s <= strength_ctl_r[3:0])) |=> !level_detect_out_o;
    endproperty
    a_detect_low: assert property (p_detect_low)
        else $error("detect output high while level is at or below threshold");

    property p_level_tracks;
        @(posedge clk_i) disable iff (reset_i)
        (!reset_i && refresh_now) |=> (level_r == $past(level_s));
    endproperty
    a_level_tracks: assert property (p_level_tracks)
        else $error("signal level not refreshed while refresh is on");

    property p_discard_on_error;
        @(posedge clk_i) disable iff (reset_i)
        (crc_fail_i && burst_rx_i && burst) |=>
            (fifo_clear_o == !$past(data_func_r[pkt_cfg_pkg::DF_KEEP_BIT]));
    endproperty
    a_discard_on_error: assert property (p_discard_on_error)
        else $error("fifo clear does not follow discard policy");
endmodule

// file: inc/pkt_cfg_pkg.sv
// Constants, field layouts and carriers for the packet data configuration bank.
// Assumes a 7-bit register address space reached over a three-wire serial link.
package pkt_cfg_pkg;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned REG_W = 8;
    localparam int unsigned LEVEL_W = 4;
    localparam int unsigned LEN_W = 5;
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned ADDR_BYTE_BITS = 8;
    localparam int unsigned REG_COUNT = 4;

    localparam logic [6:0] DATA_FUNC_ADDR = 7'h02;
    localparam logic [6:0] STRENGTH_CTL_ADDR = 7'h03;
    localparam logic [6:0] SIGNAL_VALUE_ADDR = 7'h04;
    localparam logic [6:0] DATA_FORMAT_ADDR = 7'h05;

    localparam logic [7:0] DATA_FUNC_RESET = 8'h78;
    localparam logic [7:0] STRENGTH_CTL_RESET = 8'h87;
    localparam logic [7:0] SIGNAL_VALUE_RESET = 8'h20;
    localparam logic [7:0] DATA_FORMAT_RESET = 8'h0F;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    localparam int unsigned DF_MODE_BIT = 6;
    localparam int unsigned DF_RATE_BIT = 5;
    localparam int unsigned DF_SCRAMBLE_BIT = 4;
    localparam int unsigned DF_CRC_BIT = 3;
    localparam int unsigned DF_KEEP_BIT = 0;
    localparam int unsigned SC_REFRESH_BIT = 4;
    localparam int unsigned SV_AGC_BIT = 5;
    localparam int unsigned SV_GAIN_BIT = 4;
    localparam int unsigned FMT_INSERT_BIT = 7;
    localparam int unsigned FMT_OUTPUT_BIT = 6;
    localparam int unsigned FMT_DEST_BIT = 5;

    // Datapath polynomials, feedback taps below the leading term
    localparam logic [7:0] SCRAMBLE_POLY = 8'h91;
    localparam logic [15:0] CRC_POLY = 16'h1021;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] data;
    } frame_t;

    typedef struct packed {
        logic burst_mode;
        logic bit_rate_select;
        logic scramble_enable;
        logic crc_enable;
        logic crc_keep_on_error;
        logic analog_level_refresh;
        logic [3:0] level_threshold;
        logic auto_gain_enable;
        logic level_gain_select;
        logic sender_addr_insert_n;
        logic sender_addr_output_n;
        logic dest_addr_source;
        logic [5:0] payload_bytes;
    } cfg_t;
endpackage

// file: design/cdc_sync.sv
// Two-flop level synchroniser, one stage pair per bit.
// Assumes each bit is a slow level; multi-bit words may tear for one cycle.
`timescale 1ns/100ps
module cdc_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Data
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;

    if (WIDTH < 1) begin : g_bad_width
        $error("cdc_sync needs WIDTH of at least one");
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            stage1_r <= '0;
            stage2_r <= '0;
        end else begin
            stage1_r <= d_i;
            stage2_r <= stage1_r;
        end
    end

    assign q_o = stage2_r;
endmodule

// file: sim/host_link_model.sv
// Host microcontroller model on the three-wire register port.
// Assumes the bench calls xfer from one process at a time.
`timescale 1ns/100ps
module host_link_model #(
    parameter int unsigned SETUP_NS = 20000
) (
    // Toward the device
    output logic sclk_o,
    output logic cs_o,
    output logic line_o,
    // From the device
    input wire logic dev_line_i,
    input wire logic dev_oe_i
);
    logic drive_r = 1'b0;
    logic bit_r = 1'b0;
    logic idle_r = 1'b0;

    // A short select pulse with no clock gives the port a clean falling select
    initial begin
        sclk_o = 1'b0;
        cs_o = 1'b1;
        #1;
        cs_o = 1'b0;
    end

    // Released line wanders so a stale level never passes for read data
    always #7 idle_r = ~idle_r;
    assign line_o = dev_oe_i ? dev_line_i : (drive_r ? bit_r : idle_r);

    // Link clock only runs inside a frame; slow stretches each half period
    task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdata,
                        input logic slow, output logic [7:0] rdata);
        logic [15:0] frame;
        realtime hp;
        int i;
        frame = {wr, addr, wdata};
        hp = slow ? 24.0 : 6.0;
        rdata = 8'h00;
        cs_o = 1'b1;
        #(SETUP_NS);
        #1.3;
        for (i = 15; i >= 0; i--) begin
            drive_r = wr | (i > 7);
            bit_r = frame[i];
            #(hp);
            sclk_o = 1'b1;
            if (i < 8) rdata[i] = line_o;
            #(hp);
            sclk_o = 1'b0;
        end
        drive_r = 1'b0;
        #50;
        cs_o = 1'b0;
        #100;
    endtask
endmodule

// file: sim/tb_packet_data_config_regs.sv
// Self-checking bench for the packet data configuration register bank.
// Assumes host_link_model drives the serial port; core inputs change on clk_i by NBA.
`timescale 1ns/100ps
module tb_packet_data_config_regs;
    logic clk_i = 1'b0;
    logic reset_i = 1'b0;
    logic [3:0] level = 4'h0;
    logic crc_fail = 1'b0;
    logic burst_rx = 1'b0;
    wire sclk;
    wire cs;
    wire line_in;
    logic dev_o;
    logic dev_oe;
    logic detect;
    logic fclr;
    pkt_cfg_pkg::cfg_t cfg;
    int bad_count = 0;
    int checked = 0;
    logic [7:0] regs [2:5];
    logic [3:0] hold;
    logic slow_r = 1'b0;
    int p;

    always #2.5 clk_i = ~clk_i;

    packet_data_config_regs dut (
        .clk_i(clk_i), .reset_i(reset_i), .sclk_i(sclk), .cs_i(cs),
        .serial_io_line_i(line_in), .serial_io_line_o(dev_o), .serial_io_line_oe_o(dev_oe),
        .analog_signal_level_i(level), .level_detect_out_o(detect),
        .crc_fail_i(crc_fail), .burst_rx_i(burst_rx), .fifo_clear_o(fclr), .cfg_o(cfg)
    );

    host_link_model host (
        .sclk_o(sclk), .cs_o(cs), .line_o(line_in), .dev_line_i(dev_o), .dev_oe_i(dev_oe)
    );

    task automatic complete_run();
        if (bad_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic compare(input string name, input logic [31:0] exp, input logic [31:0] seen);
        checked++;
        if (exp !== seen) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
            bad_count++;
        end
    endtask

    function automatic pkt_cfg_pkg::cfg_t exp_cfg();
        logic b;
        b = regs[2][6];
        return '{b, regs[2][5], b & regs[2][4], b & regs[2][3], regs[2][0], b | regs[3][4],
                 regs[3][3:0], !b & regs[4][5], !b & regs[4][4], !b | regs[5][7],
                 !b | regs[5][6], b & regs[5][5], {1'b0, regs[5][4:0]} + 6'h01};
    endfunction

    // Level follows the input only while refreshing
    task automatic track_level();
        if (regs[2][6] | regs[3][4]) hold = level;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] rd;
        host.xfer(1'b1, a, d, slow_r, rd);
        repeat (8) @(posedge clk_i);
        if (a >= 7'h02 && a <= 7'h05) regs[a] = d;
        track_level();
    endtask

    task automatic rdchk(input logic [6:0] a);
        logic [7:0] rd;
        logic [7:0] exp;
        host.xfer(1'b0, a, 8'h00, slow_r, rd);
        exp = 8'h00;
        if (a >= 7'h02 && a <= 7'h05) exp = regs[a];
        if (a == 7'h04) exp = {regs[4][7:4], hold};
        compare("read data", exp, rd);
        repeat (4) @(posedge clk_i);
    endtask

    task automatic check_state();
        int k;
        for (k = 0; k < 2; k++) begin
            @(posedge clk_i);
            crc_fail <= 1'b1;
            burst_rx <= k[0];
            @(posedge clk_i);
            crc_fail <= 1'b0;
            #1 compare("fifo_clear", k[0] & regs[2][6] & ~regs[2][0], fclr);
        end
        compare("cfg", exp_cfg(), cfg);
        compare("detect", level > regs[3][3:0], detect);
    endtask

    task automatic new_level(input logic [3:0] v);
        @(posedge clk_i);
        level <= v;
        repeat (6) @(posedge clk_i);
        track_level();
    endtask

    // Watchdog: a hang ends the run as a failure
    initial begin
        repeat (95000) @(posedge clk_i);
        bad_count++;
        complete_run();
    end

    initial begin
        void'($urandom(32'h9fbb32a3));
        // Raised by an edge so the link-side write latch sees its reset
        reset_i <= 1'b1;
        regs[2] = 8'h78;
        regs[3] = 8'h87;
        regs[4] = 8'h20;
        regs[5] = 8'h0F;
        hold = 4'h0;
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check_state();
        rdchk(7'h02);
        rdchk(7'h03);
        rdchk(7'h05);
        for (p = 0; p < 2; p++) begin
            slow_r = p[0];
            new_level(4'($urandom));
            wr(7'h02, (8'($urandom) & 8'h39) | (p != 0 ? 8'h40 : 8'h00));
            wr(7'h03, 8'($urandom) & (p != 0 ? 8'h1F : 8'h0F));
            wr(7'h04, 8'($urandom) & 8'h30);
            wr(7'h05, 8'($urandom));
            check_state();
            new_level(~level);
            compare("detect", level > regs[3][3:0], detect);
            rdchk(7'h04);
            rdchk(p != 0 ? 7'h05 : 7'h02);
        end
        wr(7'h07, 8'hA5);
        check_state();
        rdchk(7'h07);
        complete_run();
    end
endmodule
